// File: common/cdprs_cfg.svh
// constants for the clock distribution power, reset and alignment control
`ifndef CDPRS_CFG_SVH
`define CDPRS_CFG_SVH

`define CDPRS_ADDR_SERIAL_CFG   8'h00
`define CDPRS_ADDR_PLL_PD       8'h0a
`define CDPRS_ADDR_OUT_PD_BASE  8'h3c
`define CDPRS_ADDR_OUT_PD_LAST  8'h43
`define CDPRS_ADDR_FUNC_ALIGN   8'h58
`define CDPRS_ADDR_UPDATE       8'h5a

`define CDPRS_SOFT_RESET_BIT    5
`define CDPRS_MC_EN_BIT         0
`define CDPRS_WIN_SEL_BIT       1
`define CDPRS_SOFT_ALIGN_BIT    2
`define CDPRS_DIST_PD_BIT       3
`define CDPRS_ROLE_LSB          5
`define CDPRS_UPDATE_BIT        0

`define CDPRS_RST_SERIAL_CFG    8'h00
`define CDPRS_RST_PLL_PD        8'h00
`define CDPRS_RST_OUT_PD        8'h00
`define CDPRS_RST_FUNC_ALIGN    8'h00

`define CDPRS_NUM_OUT           8
`define CDPRS_NUM_ECL           4
`define CDPRS_WIN_WIDE_CYC      2'h1
`define CDPRS_WIN_NARROW_CYC    2'h0

`endif

// File: common/cdprs_pkg.sv
// types for the clock distribution power, reset and alignment control
package cdprs_pkg;
	typedef enum logic [1:0] {
		CDPRS_ROLE_HARD_RESET,
		CDPRS_ROLE_ALIGN,
		CDPRS_ROLE_SLEEP,
		CDPRS_ROLE_NONE
	} cdprs_role_t;

	typedef enum logic [1:0] {
		CDPRS_PLL_ON,
		CDPRS_PLL_ASYNC_PD,
		CDPRS_PLL_SYNC_PD
	} cdprs_pll_mode_t;

	typedef struct packed {
		logic       we;
		logic [7:0] addr;
		logic [7:0] wdata;
	} cdprs_wr_t;

	typedef struct packed {
		logic       pll_pd;
		logic       dist_pd;
		logic       clocks_off;
		logic       align_hold;
		logic [7:0] out_off;
		logic [3:0] ecl_safe_off;
		logic [3:0] ecl_unprot_off;
	} cdprs_pwr_t;
endpackage

// File: rtl/cdprs_align_mon.sv
// multichip slow clock coincidence monitor
`timescale 1ns/1ns
`include "cdprs_cfg.svh"
module cdprs_align_mon (
	// clock and reset
	input  wire logic ref_clk_i,
	input  wire logic sys_rst_i,
	// control
	input  wire logic enable_i,
	input  wire logic narrow_i,
	input  wire logic clear_i,
	// slow clocks already in the fast domain
	input  wire logic slow_a_i,
	input  wire logic slow_b_i,
	// flag
	output logic      out_of_sync_o
);
	import cdprs_pkg::*;

	logic       a_q;
	logic       b_q;
	logic       a_rise;
	logic       b_rise;
	logic       wait_a;
	logic       wait_b;
	logic [1:0] gap;
	logic [1:0] limit;

	assign a_rise = slow_a_i & ~a_q;
	assign b_rise = slow_b_i & ~b_q;
	assign limit  = narrow_i ? `CDPRS_WIN_NARROW_CYC : `CDPRS_WIN_WIDE_CYC;

	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			a_q <= 1'b0;
			b_q <= 1'b0;
		end else begin
			a_q <= slow_a_i;
			b_q <= slow_b_i;
		end
	end

	// track the lone edge until its partner arrives
	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			wait_a <= 1'b0;
			wait_b <= 1'b0;
			gap    <= 2'h0;
		end else if (!enable_i || (a_rise && b_rise)) begin
			wait_a <= 1'b0;
			wait_b <= 1'b0;
			gap    <= 2'h0;
		end else if (a_rise && !wait_a) begin
			wait_a <= !wait_b;
			wait_b <= 1'b0;
			gap    <= 2'h0;
		end else if (b_rise && !wait_b) begin
			wait_b <= !wait_a;
			wait_a <= 1'b0;
			gap    <= 2'h0;
		end else if ((wait_a || wait_b) && gap != 2'h3) begin
			gap <= gap + 2'h1;
		end
	end

	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			out_of_sync_o <= 1'b0;
		end else if (!enable_i) begin
			out_of_sync_o <= 1'b0;
		end else if ((wait_a || wait_b) && gap >= limit) begin
			out_of_sync_o <= 1'b1;
		end else if (clear_i) begin
			out_of_sync_o <= 1'b0;
		end
	end
endmodule

// File: rtl/cdprs_ctrl.sv
// power, reset and output alignment control with staged registers
`timescale 1ns/1ns
`include "cdprs_cfg.svh"
module cdprs_ctrl (
	// clock and power-on reset
	input  wire logic                 ref_clk_i,
	input  wire logic                 sys_rst_i,
	// staged write from the serial configuration port
	input  wire cdprs_pkg::cdprs_wr_t wr_i,
	input  wire logic [7:0]           rd_addr_i,
	output logic [7:0]                rd_data_o,
	// multi-role pin, charge pump event, slow clocks
	input  wire logic                 func_pin_i,
	input  wire logic                 cp_event_i,
	input  wire logic                 slow_ref_i,
	input  wire logic                 slow_fb_i,
	// controls to the analogue and distribution sections
	output cdprs_pkg::cdprs_pwr_t     pwr_o,
	output logic                      soft_reset_o,
	output logic                      monitor_o
);
	import cdprs_pkg::*;

	// staged (buffer) and active copies
	logic [7:0] stg_cfg;
	logic [7:0] stg_pll;
	logic [7:0] stg_func;
	logic [7:0] stg_out [`CDPRS_NUM_OUT];
	logic [7:0] act_pll;
	logic [7:0] act_func;
	logic [7:0] act_out [`CDPRS_NUM_OUT];
	logic       update;
	logic       hard_rst;
	logic       pin_s1;
	logic       pin_s2;
	logic       soft_rst;
	logic       pll_pd_q;
	logic       sleep;
	logic       pin_align;
	logic       oos;
	logic [7:0] rd_out;
	cdprs_role_t     role;
	cdprs_pll_mode_t pll_mode;

	function automatic cdprs_pll_mode_t pll_decode(input logic [1:0] f);
		case (f)
			2'b01:   pll_decode = CDPRS_PLL_ASYNC_PD;
			2'b11:   pll_decode = CDPRS_PLL_SYNC_PD;
			default: pll_decode = CDPRS_PLL_ON;
		endcase
	endfunction

	function automatic logic is_out(input logic [7:0] a);
		is_out = (a >= `CDPRS_ADDR_OUT_PD_BASE) &&
			(a <= `CDPRS_ADDR_OUT_PD_LAST);
	endfunction

	assign soft_rst = stg_cfg[`CDPRS_SOFT_RESET_BIT];
	assign update   = wr_i.we && wr_i.addr == `CDPRS_ADDR_UPDATE &&
		wr_i.wdata[`CDPRS_UPDATE_BIT];
	assign role     = cdprs_role_t'(act_func[`CDPRS_ROLE_LSB +: 2]);
	assign pll_mode = pll_decode(act_pll[1:0]);

	assign hard_rst = sys_rst_i ||
		(role == CDPRS_ROLE_HARD_RESET && !func_pin_i);

	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			pin_s1 <= 1'b1;
			pin_s2 <= 1'b1;
		end else begin
			pin_s1 <= func_pin_i;
			pin_s2 <= pin_s1;
		end
	end

	// serial config register: survives soft reset
	always_ff @(posedge ref_clk_i or posedge hard_rst) begin
		if (hard_rst) begin
			stg_cfg <= `CDPRS_RST_SERIAL_CFG;
		end else if (wr_i.we && wr_i.addr == `CDPRS_ADDR_SERIAL_CFG) begin
			stg_cfg <= wr_i.wdata;
		end
	end

	// staged registers; writes land here during sleep too
	// sleep keeps staged writes
	always_ff @(posedge ref_clk_i or posedge hard_rst) begin
		if (hard_rst) begin
			stg_pll  <= `CDPRS_RST_PLL_PD;
			stg_func <= `CDPRS_RST_FUNC_ALIGN;
		end else if (soft_rst) begin
			stg_pll  <= `CDPRS_RST_PLL_PD;
			stg_func <= `CDPRS_RST_FUNC_ALIGN;
		end else if (wr_i.we) begin
			if (wr_i.addr == `CDPRS_ADDR_PLL_PD)
				stg_pll <= wr_i.wdata;
			if (wr_i.addr == `CDPRS_ADDR_FUNC_ALIGN)
				stg_func <= wr_i.wdata;
		end
	end

	// active copies move together on update
	always_ff @(posedge ref_clk_i or posedge hard_rst) begin
		if (hard_rst) begin
			act_pll  <= `CDPRS_RST_PLL_PD;
			act_func <= `CDPRS_RST_FUNC_ALIGN;
		end else if (soft_rst) begin
			act_pll  <= `CDPRS_RST_PLL_PD;
			act_func <= `CDPRS_RST_FUNC_ALIGN;
		end else if (update) begin
			act_pll  <= stg_pll;
			act_func <= stg_func;
		end
	end

	for (genvar i = 0; i < `CDPRS_NUM_OUT; i++) begin : g_out
		always_ff @(posedge ref_clk_i or posedge hard_rst) begin
			if (hard_rst) begin
				stg_out[i] <= `CDPRS_RST_OUT_PD;
				act_out[i] <= `CDPRS_RST_OUT_PD;
			end else if (soft_rst) begin
				stg_out[i] <= `CDPRS_RST_OUT_PD;
				act_out[i] <= `CDPRS_RST_OUT_PD;
			end else begin
				if (wr_i.we && wr_i.addr == `CDPRS_ADDR_OUT_PD_BASE + 8'(i))
					stg_out[i] <= wr_i.wdata;
				if (update)
					act_out[i] <= stg_out[i];
			end
		end
		if (i < `CDPRS_NUM_ECL) begin : g_ecl
			assign pwr_o.ecl_safe_off[i] = sleep ||
				act_out[i][1:0] == 2'b10;
			assign pwr_o.ecl_unprot_off[i] = !sleep &&
				act_out[i][1:0] == 2'b11;
			assign pwr_o.out_off[i] = sleep || act_out[i][1];
		end else begin : g_lvds
			assign pwr_o.out_off[i] = sleep || act_out[i][0];
		end
	end

	assign sleep     = role == CDPRS_ROLE_SLEEP && !pin_s2;
	assign pin_align = role == CDPRS_ROLE_ALIGN && !pin_s2;

	// PLL power-down state
	always_ff @(posedge ref_clk_i or posedge hard_rst) begin
		if (hard_rst) begin
			pll_pd_q <= 1'b0;
		end else begin
			case (pll_mode)
				CDPRS_PLL_ASYNC_PD: pll_pd_q <= 1'b1;
				CDPRS_PLL_SYNC_PD:  pll_pd_q <= pll_pd_q | cp_event_i;
				CDPRS_PLL_ON:       pll_pd_q <= 1'b0;
				default:            pll_pd_q <= 1'b0;
			endcase
		end
	end

	assign pwr_o.pll_pd     = pll_pd_q || sleep;
	assign pwr_o.dist_pd    = act_func[`CDPRS_DIST_PD_BIT];
	assign pwr_o.clocks_off = sleep;
	assign pwr_o.align_hold = sleep || pin_align ||
		act_func[`CDPRS_SOFT_ALIGN_BIT];
	assign soft_reset_o     = soft_rst;

	cdprs_align_mon u_mon (
		.ref_clk_i     (ref_clk_i),
		.sys_rst_i     (hard_rst),
		.enable_i      (act_func[`CDPRS_MC_EN_BIT] && !sleep),
		.narrow_i      (act_func[`CDPRS_WIN_SEL_BIT]),
		.clear_i       (pin_align),
		.slow_a_i      (slow_ref_i),
		.slow_b_i      (slow_fb_i),
		.out_of_sync_o (oos)
	);

	// flag on monitor pin, low in sync
	always_ff @(posedge ref_clk_i or posedge hard_rst) begin
		if (hard_rst)
			monitor_o <= 1'b0;
		else
			monitor_o <= act_func[`CDPRS_MC_EN_BIT] & oos;
	end

	// readback shows the buffer, not the active copy
	always_comb begin
		rd_out = 8'h00;
		if (rd_addr_i == `CDPRS_ADDR_SERIAL_CFG)
			rd_out = stg_cfg;
		else if (rd_addr_i == `CDPRS_ADDR_PLL_PD)
			rd_out = stg_pll;
		else if (rd_addr_i == `CDPRS_ADDR_FUNC_ALIGN)
			rd_out = stg_func;
		else if (is_out(rd_addr_i))
			rd_out = stg_out[3'(rd_addr_i - `CDPRS_ADDR_OUT_PD_BASE)];
	end

	always_ff @(posedge ref_clk_i or posedge hard_rst) begin
		if (hard_rst)
			rd_data_o <= 8'h00;
		else
			rd_data_o <= rd_out;
	end
endmodule

// File: dv/cdprs_chk.sv
// port assertions for the power, reset and alignment control
`timescale 1ns/1ns
module cdprs_chk (
	// clock and reset
	input wire logic                 ref_clk_i,
	input wire logic                 sys_rst_i,
	// host side
	input wire cdprs_pkg::cdprs_wr_t wr_i,
	input wire logic [7:0]           rd_addr_i,
	input wire logic [7:0]           rd_data_o,
	input wire logic                 func_pin_i,
	input wire logic                 cp_event_i,
	input wire logic                 slow_ref_i,
	input wire logic                 slow_fb_i,
	// control side
	input wire cdprs_pkg::cdprs_pwr_t pwr_o,
	input wire logic                 soft_reset_o,
	input wire logic                 monitor_o
);
	import cdprs_pkg::*;
	default clocking @(posedge ref_clk_i);
	endclocking
	default disable iff (sys_rst_i);
	// pin held high so the hard reset path stays out of the way
	sequence s_upd(logic [1:0] m);
		wr_i.we && wr_i.addr == 8'h0a && wr_i.wdata[1:0] == m && func_pin_i
		##1 wr_i.we && wr_i.addr == 8'h5a && wr_i.wdata[0] && func_pin_i
		&& !soft_reset_o;
	endsequence
	a_soft_follow: assert property (
		wr_i.we && wr_i.addr == 8'h00 && func_pin_i ##1 func_pin_i
		|-> soft_reset_o == $past(wr_i.wdata[5]))
		else $error("soft reset bit not following its write");
	a_soft_hold: assert property (
		soft_reset_o && !(wr_i.we && wr_i.addr == 8'h00) ##1 func_pin_i
		|-> soft_reset_o)
		else $error("soft reset bit cleared without a write");
	a_soft_clears: assert property (
		soft_reset_o [*3] |-> pwr_o == '0
		&& ($past(rd_addr_i) == 8'h00 || rd_data_o == 8'h00))
		else $error("registers not held at default in soft reset");
	a_read_staged: assert property (
		wr_i.we && wr_i.addr == 8'h0a && rd_addr_i == 8'h0a && func_pin_i
		&& !soft_reset_o ##1 !wr_i.we && rd_addr_i == 8'h0a && func_pin_i
		|=> rd_data_o == $past(wr_i.wdata, 2))
		else $error("staged value not read back");
	a_pll_async: assert property (
		s_upd(2'b01) |-> ##[1:2] pwr_o.pll_pd)
		else $error("asynchronous power-down not taken");
	a_pll_sync_wait: assert property (
		!pwr_o.pll_pd ##0 s_upd(2'b11) ##0 !cp_event_i [*3]
		|-> !pwr_o.pll_pd)
		else $error("synchronous power-down before pump event");
	a_ecl_modes: assert property (
		!pwr_o.clocks_off |-> (pwr_o.ecl_safe_off & pwr_o.ecl_unprot_off)
		== 4'h0 && pwr_o.out_off[3:0] ==
		(pwr_o.ecl_safe_off | pwr_o.ecl_unprot_off))
		else $error("emitter output mode decode wrong");
	a_sleep_state: assert property (
		pwr_o.clocks_off |-> pwr_o.pll_pd && pwr_o.ecl_safe_off == 4'hf
		&& pwr_o.out_off[7:4] == 4'hf)
		else $error("sleep state incomplete");
endmodule
bind cdprs_ctrl cdprs_chk u_cdprs_chk (.ref_clk_i, .sys_rst_i, .wr_i,
	.rd_addr_i, .rd_data_o, .func_pin_i, .cp_event_i, .slow_ref_i,
	.slow_fb_i, .pwr_o, .soft_reset_o, .monitor_o);

// File: dv/cdprs_host.sv
// host model: staged register writes and the multi-role pin
`timescale 1ns/1ns
module cdprs_host (
	// clock
	input  wire logic            ref_clk_i,
	// toward the block
	output cdprs_pkg::cdprs_wr_t wr_o,
	output logic                 pin_o
);
	import cdprs_pkg::*;
	initial begin
		wr_o = '0;
		pin_o = 1'b1;
	end
	// one byte per edge, held until the taking edge
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		wr_o = '{1'b1, a, d};
		@(posedge ref_clk_i);
		#1;
	endtask
	task automatic idle();
		wr_o.we = 1'b0;
		@(posedge ref_clk_i);
		#1;
	endtask
	task automatic upd(input logic [7:0] a, input logic [7:0] d);
		wr(a, d);
		wr(8'h5a, 8'h01);
		idle();
	endtask
	task automatic pin(input logic v);
		pin_o = v;
	endtask
endmodule

// File: dv/test_clock_dist_power_reset_sync_ctrl.sv
// self-checking bench for the power, reset and alignment control
`timescale 1ns/1ns
module test_clock_dist_power_reset_sync_ctrl;
	import cdprs_pkg::*;
	logic       clk = 1'b0;
	logic       sys_rst_i = 1'b1;
	logic [7:0] rd_addr_i = 8'h00;
	logic       cp_event_i = 1'b0;
	logic [2:0] cnt = 3'h0;
	logic [2:0] skew = 3'h0;
	logic [2:0] fbc;
	logic [7:0] rd_data_o;
	logic [7:0] rnd = 8'h28;
	logic       pin;
	logic       soft_reset_o;
	logic       monitor_o;
	cdprs_wr_t  wr;
	cdprs_pwr_t pwr_o;
	int         miscompares = 0;
	int         samples_checked = 0;
	int         cyc = 0;
	int         stg[256];
	int         act[256];
	int         mt[4] = '{2, 4, 7, 9};
	always #5 clk = ~clk;
	// slow clocks at an eighth of the fast one
	always @(posedge clk) begin
		cyc <= cyc + 1;
		cnt <= cnt + 3'h1;
		if (cyc == 5000) begin
			miscompares++;
			complete_run();
		end
	end
	assign fbc = cnt - skew;
	cdprs_host u_cdprs_host (.ref_clk_i(clk), .wr_o(wr), .pin_o(pin));
	cdprs_ctrl u_cdprs_ctrl (.ref_clk_i(clk), .sys_rst_i, .wr_i(wr),
		.rd_addr_i, .rd_data_o, .func_pin_i(pin), .cp_event_i,
		.slow_ref_i(cnt[2]), .slow_fb_i(fbc[2]), .pwr_o, .soft_reset_o,
		.monitor_o);
	task automatic complete_run();
		$display("checked %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		samples_checked++;
		if (g !== e) begin
			miscompares++;
			$display("ERROR %0t got %h exp %h", $time, g, e);
		end
	endtask
	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction
	function automatic logic [31:0] rexp(input int a);
		if (a == 0 || a == 10 || a == 88 || (a >= 60 && a <= 67))
			return stg[a];
		return 0;
	endfunction
	function automatic cdprs_pwr_t pm();
		cdprs_pwr_t p;
		int         m;
		p = '0;
		p.pll_pd = act[10][0];
		p.dist_pd = act[88][3];
		p.align_hold = act[88][2];
		for (int i = 0; i < 8; i++) begin
			m = act[60 + i];
			p.out_off[i] = (i < 4) ? m[1] : m[0];
			if (i < 4) begin
				p.ecl_safe_off[i] = m[1:0] == 2'h2;
				p.ecl_unprot_off[i] = m[1:0] == 2'h3;
			end
		end
		return p;
	endfunction
	// model: soft reset zeroes all but its own register
	task automatic wm(input int a, input int d);
		int s;
		if (a == 0 || !stg[0][5])
			stg[a] = d;
		if (a == 90 && d[0] && !stg[0][5])
			act = stg;
		s = stg[0];
		if (s[5]) begin
			stg = '{default: 0};
			act = stg;
			stg[0] = s;
		end
	endtask
	task automatic tk(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic rd(input int a);
		rd_addr_i = a[7:0];
		tk(1);
		chk(rd_data_o, rexp(a));
	endtask
	task automatic w1(input int a, input int d);
		wm(a, d);
		u_cdprs_host.wr(a[7:0], d[7:0]);
		u_cdprs_host.idle();
	endtask
	task automatic upd(input int a, input int d);
		wm(a, d);
		wm(90, 1);
		u_cdprs_host.upd(a[7:0], d[7:0]);
	endtask
	// two edges of synchroniser plus margin
	task automatic pw(input logic v);
		u_cdprs_host.pin(v);
		tk(3);
	endtask
	initial begin
		tk(6);
		sys_rst_i = 1'b0;
		for (int a = 0; a < 96; a++)
			rd(a);
		for (int k = 0; k < 2; k++) begin
			for (int i = 0; i < 8; i++) begin
				rnd = lfsr(rnd);
				w1(60 + i, rnd);
			end
			rd(10);
			rnd = lfsr(rnd);
			w1(10, rnd & 8'h01);
			rnd = lfsr(rnd);
			w1(88, rnd & 8'h04);
			chk(pwr_o, pm());
			for (int i = 0; i < 8; i++)
				rd(60 + i);
			w1(90, 1);
			chk(pwr_o, pm());
		end
		for (int m = 0; m < 4; m++) begin
			upd(10, m);
			if (m == 3) begin
				tk(2);
				chk(pwr_o.pll_pd, 0);
				cp_event_i = 1'b1;
				tk(1);
				cp_event_i = 1'b0;
				tk(1);
			end
			chk(pwr_o.pll_pd, m == 1 || m == 3);
		end
		upd(88, 8'h40);
		pw(1'b0);
		chk(pwr_o.clocks_off, 1);
		chk(pwr_o.pll_pd, 1);
		chk({pwr_o.out_off[7:4], pwr_o.ecl_safe_off}, 8'hff);
		upd(10, 1);
		rd(10);
		pw(1'b1);
		chk(pwr_o, pm());
		upd(88, 8'h44);
		chk(pwr_o.align_hold, 1);
		upd(88, 8'h40);
		chk(pwr_o.align_hold, 0);
		upd(88, 8'h20);
		pw(1'b0);
		chk(pwr_o.align_hold, 1);
		pw(1'b1);
		chk(pwr_o.align_hold, 0);
		foreach (mt[j]) begin
			skew = mt[j][4:2];
			upd(88, 0);
			chk(monitor_o, 0);
			upd(88, {mt[j][1], 1'b1});
			tk(24);
			chk(monitor_o, mt[j][0]);
		end
		// flag is sticky until the align pin pulses low
		skew = 3'h0;
		upd(88, 8'h21);
		tk(8);
		chk(monitor_o, 1);
		pw(1'b0);
		pw(1'b1);
		chk(monitor_o, 0);
		upd(88, 8'h08);
		chk(pwr_o.dist_pd, 1);
		w1(0, 8'h20);
		chk(soft_reset_o, 1);
		w1(88, 8'h44);
		rd(88);
		chk(pwr_o, 0);
		w1(0, 0);
		chk(soft_reset_o, 0);
		upd(10, 1);
		chk(pwr_o.pll_pd, 1);
		// one more edge so the power-down is seen before the pin reset
		tk(1);
		pw(1'b0);
		stg = '{default: 0};
		act = stg;
		pw(1'b1);
		rd(10);
		chk(pwr_o, 0);
		complete_run();
	end
endmodule
